// file: src/sgp_gpio_top.sv
// Behaviour
// - Eight-bit shared port data latch is read/write; reset leaves it alone.
// - Eight-bit port direction: 1 drives the pin, 0 inputs; reset clears.
// - Eight-bit port read: latch if output, else pin, or 0 if converter.
// - Data latches always accept writes; input pins read the pin anyway.
// - Channel select picks converter use; such pins never drive.
// - Converter pin with direction 1 reads the latch but stays high-Z.
// - Five-bit clock port latch is read/write; reset leaves it alone.
// - Direction bit 7 enables bus clock out on pin 2; reset clears.
// - With clock out enabled pin 2 drives the bus clock regardless.
// - Five clock port direction bits: 1 drives, 0 inputs; reset clears.
// - Clock port read: latch if output, else the pin level.
// - Seven-bit shared port latch is read/write, direction per bit.
// - Seven-bit pins are channels 8 to 14; selected input reads 0.
// - Seven-bit port direction: 1 drives, 0 inputs; reset clears.
`timescale 1ns/1ps
`include "sgp_map.svh"

module sgp_gpio_top
  import sgp_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`SGP_ADDR_WIDTH-1:0] i_paddr,
  input wire logic [`SGP_DATA_WIDTH-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [`SGP_DATA_WIDTH-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Converter channel select, same clock domain
  input wire logic [`SGP_CH_WIDTH-1:0] i_converter_channel_select,
  // Eight-bit converter-shared port pads
  input wire logic [`SGP_PORT_B_WIDTH-1:0] i_port_b_pin,
  output logic [`SGP_PORT_B_WIDTH-1:0] o_port_b_out,
  output logic [`SGP_PORT_B_WIDTH-1:0] o_port_b_oe,
  // Clock port pads
  input wire logic [`SGP_PORT_C_WIDTH-1:0] i_port_c_pin,
  output logic [`SGP_PORT_C_WIDTH-1:0] o_port_c_out,
  output logic [`SGP_PORT_C_WIDTH-1:0] o_port_c_oe,
  // Seven-bit converter-shared port pads
  input wire logic [`SGP_PORT_D_WIDTH-1:0] i_port_d_pin,
  output logic [`SGP_PORT_D_WIDTH-1:0] o_port_d_out,
  output logic [`SGP_PORT_D_WIDTH-1:0] o_port_d_oe,
  // Converter routing, registered for the converter mux
  output logic [`SGP_PORT_B_WIDTH-1:0] o_converter_channels_low,
  output logic [`SGP_PORT_D_WIDTH-1:0] o_converter_channels_high
);

  localparam int BW = `SGP_PORT_B_WIDTH;
  localparam int CW = `SGP_PORT_C_WIDTH;
  localparam int DW = `SGP_PORT_D_WIDTH;

  // Bus phase and decode
  sgp_decode_type dec;
  logic setup_phase;
  logic wr_commit;
  logic [`SGP_DATA_WIDTH-1:0] read_mux;
  logic pready_q;
  logic pslverr_q;
  logic [`SGP_DATA_WIDTH-1:0] prdata_q;

  // Per-port write strobes
  logic wr_b_data;
  logic wr_b_dir;
  logic wr_c_data;
  logic wr_c_dir;
  logic wr_d_data;
  logic wr_d_dir;

  // Converter routing
  logic [BW-1:0] analog_b;
  logic [DW-1:0] analog_d;
  logic [BW-1:0] analog_b_q;
  logic [DW-1:0] analog_d_q;

  // Clock output state
  logic clkout_en_q;
  logic bus_clk_q;
  logic [CW-1:0] c_force_oe;
  logic [CW-1:0] c_force_out;

  // Port views
  logic [BW-1:0] b_dir;
  logic [BW-1:0] b_read;
  logic [CW-1:0] c_dir;
  logic [CW-1:0] c_read;
  logic [DW-1:0] d_dir;
  logic [DW-1:0] d_read;

  // Address decode; misaligned or high addresses hit nothing
  always_comb begin
    dec.hit = 1'b0;
    dec.sel = SGP_REG_NONE;
    if (i_paddr[1:0] == 2'h0 && i_paddr[`SGP_ADDR_WIDTH-1:6] == '0) begin
      dec.hit = 1'b1;
      case (i_paddr[5:2])
        `SGP_IDX_PORT_B_DATA: begin
          dec.sel = SGP_REG_B_DATA;
        end
        `SGP_IDX_PORT_C_DATA: begin
          dec.sel = SGP_REG_C_DATA;
        end
        `SGP_IDX_PORT_D_DATA: begin
          dec.sel = SGP_REG_D_DATA;
        end
        `SGP_IDX_PORT_B_DIR: begin
          dec.sel = SGP_REG_B_DIR;
        end
        `SGP_IDX_PORT_C_DIR: begin
          dec.sel = SGP_REG_C_DIR;
        end
        `SGP_IDX_PORT_D_DIR: begin
          dec.sel = SGP_REG_D_DIR;
        end
        default: begin
          dec.hit = 1'b0;
          dec.sel = SGP_REG_NONE;
        end
      endcase
    end
  end

  // Setup cycle schedules the answer; write lands in the access edge
  assign setup_phase = i_psel && !i_penable;
  assign wr_commit = i_psel && i_penable && pready_q && i_pwrite && dec.hit && i_pstrb[0];

  // Only the low byte lane carries register data
  assign wr_b_data = wr_commit && dec.sel == SGP_REG_B_DATA;
  assign wr_b_dir = wr_commit && dec.sel == SGP_REG_B_DIR;
  assign wr_c_data = wr_commit && dec.sel == SGP_REG_C_DATA;
  assign wr_c_dir = wr_commit && dec.sel == SGP_REG_C_DIR;
  assign wr_d_data = wr_commit && dec.sel == SGP_REG_D_DATA;
  assign wr_d_dir = wr_commit && dec.sel == SGP_REG_D_DIR;

  // Channel select to per-pin converter ownership; 15 and up select none
  always_comb begin
    for (int i = 0; i < BW; i++) begin
      analog_b[i] = i_converter_channel_select ==
        `SGP_CH_LOW_BASE + i[`SGP_CH_WIDTH-1:0];
    end
    for (int i = 0; i < DW; i++) begin
      analog_d[i] = i_converter_channel_select ==
        `SGP_CH_HIGH_BASE + i[`SGP_CH_WIDTH-1:0];
    end
  end

  // Clock output enable lives in bit 7 of the clock port direction
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      clkout_en_q <= `SGP_CLKOUT_EN_RESET;
    end else if (i_ce && wr_c_dir) begin
      clkout_en_q <= i_pwdata[`SGP_CLKOUT_EN_BIT];
    end
  end

  // Bus clock image for the pad: a divide-by-two toggle of the core clock
  // Trade-off: half rate keeps the pad on a plain flop, no gated clock path
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      bus_clk_q <= 1'b0;
    end else if (i_ce) begin
      bus_clk_q <= clkout_en_q ? !bus_clk_q : 1'b0;
    end
  end

  // Pin 2 is taken over while the clock output is enabled
  always_comb begin
    c_force_oe = '0;
    c_force_out = '0;
    c_force_oe[`SGP_CLKOUT_PIN] = clkout_en_q;
    c_force_out[`SGP_CLKOUT_PIN] = bus_clk_q;
  end

  // Eight-bit converter-shared port
  sgp_port #(
    .WIDTH(BW)
  ) u_port_b (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_wr_data(i_pwdata[BW-1:0]),
    .i_wr_latch(wr_b_data),
    .i_wr_dir(wr_b_dir),
    .i_analog_sel(analog_b),
    .i_force_oe('0),
    .i_force_out('0),
    .i_pin(i_port_b_pin),
    .o_pin_out(o_port_b_out),
    .o_pin_oe(o_port_b_oe),
    .o_dir(b_dir),
    .o_read(b_read)
  );

  // Clock port, no converter sharing
  sgp_port #(
    .WIDTH(CW)
  ) u_port_c (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_wr_data(i_pwdata[CW-1:0]),
    .i_wr_latch(wr_c_data),
    .i_wr_dir(wr_c_dir),
    .i_analog_sel('0),
    .i_force_oe(c_force_oe),
    .i_force_out(c_force_out),
    .i_pin(i_port_c_pin),
    .o_pin_out(o_port_c_out),
    .o_pin_oe(o_port_c_oe),
    .o_dir(c_dir),
    .o_read(c_read)
  );

  // Seven-bit converter-shared port
  sgp_port #(
    .WIDTH(DW)
  ) u_port_d (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_wr_data(i_pwdata[DW-1:0]),
    .i_wr_latch(wr_d_data),
    .i_wr_dir(wr_d_dir),
    .i_analog_sel(analog_d),
    .i_force_oe('0),
    .i_force_out('0),
    .i_pin(i_port_d_pin),
    .o_pin_out(o_port_d_out),
    .o_pin_oe(o_port_d_oe),
    .o_dir(d_dir),
    .o_read(d_read)
  );

  // Read mux; unimplemented bits are zero-extended away
  // Direction reads never expose the unused clock port bits 6 and 5
  always_comb begin
    read_mux = '0;
    case (dec.sel)
      SGP_REG_B_DATA: begin
        read_mux[BW-1:0] = b_read;
      end
      SGP_REG_C_DATA: begin
        read_mux[CW-1:0] = c_read;
      end
      SGP_REG_D_DATA: begin
        read_mux[DW-1:0] = d_read;
      end
      SGP_REG_B_DIR: begin
        read_mux[BW-1:0] = b_dir;
      end
      SGP_REG_C_DIR: begin
        read_mux[CW-1:0] = c_dir;
        read_mux[`SGP_CLKOUT_EN_BIT] = clkout_en_q;
      end
      SGP_REG_D_DIR: begin
        read_mux[DW-1:0] = d_dir;
      end
      default: begin
        read_mux = '0;
      end
    endcase
  end

  // Zero-wait answer: ready and data are loaded in the setup cycle
  // Data is captured in setup, so a read shows state before its own access
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else if (i_ce) begin
      pready_q <= setup_phase;
      pslverr_q <= setup_phase && !dec.hit;
      prdata_q <= (setup_phase && !i_pwrite) ? read_mux : '0;
    end
  end

  // Converter routing flags for the analog mux
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      analog_b_q <= '0;
      analog_d_q <= '0;
    end else if (i_ce) begin
      analog_b_q <= analog_b;
      analog_d_q <= analog_d;
    end
  end

  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_prdata = prdata_q;
  assign o_converter_channels_low = analog_b_q;
  assign o_converter_channels_high = analog_d_q;

endmodule

// file: src/sgp_map.svh
`ifndef SGP_MAP_SVH
`define SGP_MAP_SVH

// Register indices; byte address is four times the index
`define SGP_IDX_PORT_B_DATA 4'h1
`define SGP_IDX_PORT_C_DATA 4'h2
`define SGP_IDX_PORT_D_DATA 4'h3
`define SGP_IDX_PORT_B_DIR 4'h5
`define SGP_IDX_PORT_C_DIR 4'h6
`define SGP_IDX_PORT_D_DIR 4'h7

// Port widths
`define SGP_PORT_B_WIDTH 8
`define SGP_PORT_C_WIDTH 5
`define SGP_PORT_D_WIDTH 7

// Field positions
`define SGP_CLKOUT_EN_BIT 7
`define SGP_CLKOUT_PIN 2

// Converter channel numbering
`define SGP_CH_WIDTH 5
`define SGP_CH_LOW_BASE 5'h00
`define SGP_CH_HIGH_BASE 5'h08

// Reset values
`define SGP_DIR_RESET 8'h00
`define SGP_CLKOUT_EN_RESET 1'h0

// Bus geometry
`define SGP_ADDR_WIDTH 12
`define SGP_DATA_WIDTH 32

`endif

// file: src/sgp_pkg.sv
package sgp_pkg;

  // Which register an APB address selects
  typedef enum logic [2:0] {
    SGP_REG_NONE = 3'h0,
    SGP_REG_B_DATA = 3'h1,
    SGP_REG_C_DATA = 3'h3,
    SGP_REG_D_DATA = 3'h2,
    SGP_REG_B_DIR = 3'h6,
    SGP_REG_C_DIR = 3'h7,
    SGP_REG_D_DIR = 3'h5
  } sgp_reg_type;

  // Result of address decode
  typedef struct packed {
    logic hit;
    sgp_reg_type sel;
  } sgp_decode_type;

  // One pad's drive pair
  typedef struct packed {
    logic out;
    logic oe;
  } sgp_drive_type;

endpackage

// file: src/sgp_port.sv
`timescale 1ns/1ps
`include "sgp_map.svh"

module sgp_port
  import sgp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Register writes
  input wire logic [WIDTH-1:0] i_wr_data,
  input wire logic i_wr_latch,
  input wire logic i_wr_dir,
  // Alternate function controls
  input wire logic [WIDTH-1:0] i_analog_sel,
  input wire logic [WIDTH-1:0] i_force_oe,
  input wire logic [WIDTH-1:0] i_force_out,
  // Pads
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_pin_out,
  output logic [WIDTH-1:0] o_pin_oe,
  // Register views
  output logic [WIDTH-1:0] o_dir,
  output logic [WIDTH-1:0] o_read
);

  logic [WIDTH-1:0] latch_q;
  logic [WIDTH-1:0] dir_q;
  logic [WIDTH-1:0] sync1_q;
  logic [WIDTH-1:0] sync2_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] oe_q;

  // Data latch has no reset; software must load it before use
  always_ff @(posedge i_clk) begin
    if (i_ce && i_wr_latch) begin
      latch_q <= i_wr_data;
    end
  end

  // Direction bits clear to inputs on reset
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      dir_q <= '0;
    end else if (i_ce && i_wr_dir) begin
      dir_q <= i_wr_data;
    end
  end

  // Two-stage synchroniser; only the second stage is read
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (i_ce) begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
    end
  end

  // Registered pad drive; converter use blocks the buffer
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      oe_q <= '0;
      out_q <= '0;
    end else if (i_ce) begin
      oe_q <= i_force_oe | (dir_q & ~i_analog_sel);
      out_q <= (i_force_oe & i_force_out) | (~i_force_oe & latch_q);
    end
  end

  // Read view: latch for outputs, pin or zero for inputs
  always_comb begin
    o_read = (dir_q & latch_q) | (~dir_q & ~i_analog_sel & sync2_q);
  end

  assign o_dir = dir_q;
  assign o_pin_out = out_q;
  assign o_pin_oe = oe_q;

endmodule

// file: bench/sgp_sva.sv
`timescale 1ns/1ps
module sgp_sva (
  // Clock, reset and bus
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Pads and converter routing
  input wire logic [4:0] i_converter_channel_select,
  input wire logic [7:0] o_port_b_oe,
  input wire logic [4:0] o_port_c_oe,
  input wire logic [4:0] o_port_c_out,
  input wire logic [6:0] o_port_d_oe,
  input wire logic [7:0] o_converter_channels_low,
  input wire logic [6:0] o_converter_channels_high
);
  logic [4:0] s;
  // Short alias for the channel select
  assign s = i_converter_channel_select;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  AST_READY: assert property (i_psel && !i_penable |=> o_pready ##1 !o_pready)
    else $error("bus answer not a single cycle");
  AST_ERR: assert property (i_psel && !i_penable && i_paddr == 12'h010 |=> o_pslverr)
    else $error("unmapped access not flagged");
  AST_UPPER: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
    else $error("unused read bits not zero");
  AST_OE_B: assert property (s < 5'h08 && $past(s) == s && $past(s, 2) == s
    |-> !o_port_b_oe[s[2:0]])
    else $error("converter pin on port B driven");
  AST_OE_D: assert property (s > 5'h07 && s < 5'h0F && $past(s) == s && $past(s, 2) == s
    |-> !o_port_d_oe[s[2:0]])
    else $error("converter pin on port D driven");
  AST_LOW: assert property (!$past(i_reset) |-> o_converter_channels_low ==
    ($past(s) < 5'h08 ? 8'h01 << $past(s[2:0]) : 8'h00))
    else $error("low channel routing wrong");
  AST_HIGH: assert property (!$past(i_reset) |-> o_converter_channels_high ==
    ($past(s) > 5'h07 && $past(s) < 5'h0F ? 7'h01 << $past(s[2:0]) : 7'h00))
    else $error("high channel routing wrong");
  AST_CLK: assert property (o_pready && i_pwrite && i_paddr == 12'h018 && i_pwdata[7]
    |-> ##3 (o_port_c_oe[2] && o_port_c_out[2] != $past(o_port_c_out[2]))[*4])
    else $error("bus clock not driven on pin 2");
  AST_RST_OE: assert property ($past(i_reset) |-> o_port_b_oe == 8'h00
    && o_port_c_oe == 5'h00 && o_port_d_oe == 7'h00)
    else $error("pads driven after reset");
endmodule

// file: bench/sgp_pads.sv
`timescale 1ns/1ps
module sgp_pads (
  // Pad drive from the ports
  input wire logic [19:0] i_oe,
  input wire logic [19:0] i_out,
  // Outside levels and resolved pads
  input wire logic [19:0] i_ext,
  output logic [19:0] o_lvl
);
  // A driven pad shows the port, else the outside world
  assign o_lvl = (i_oe & i_out) | (~i_oe & i_ext);
endmodule

// file: bench/sgp_gpio_top_tb_top.sv
`timescale 1ns/1ps
module sgp_gpio_top_tb_top;
  logic i_clk, i_reset, i_ce, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic [3:0] i_pstrb;
  logic [4:0] i_converter_channel_select, i_port_c_pin, o_port_c_out, o_port_c_oe;
  logic [7:0] i_port_b_pin, o_port_b_out, o_port_b_oe, o_converter_channels_low;
  logic [6:0] i_port_d_pin, o_port_d_out, o_port_d_oe, o_converter_channels_high;
  logic [19:0] ext, lvl;
  logic [9:0] q[$];
  logic [9:0] n;
  logic [7:0] vb, vc, vd;
  int fails, n_checks, cyc;

  sgp_gpio_top sgp_gpio_top_inst (.*);
  sgp_pads sgp_pads_inst (
    .i_oe({o_port_b_oe, o_port_c_oe, o_port_d_oe}),
    .i_out({o_port_b_out, o_port_c_out, o_port_d_out}),
    .i_ext(ext),
    .o_lvl(lvl)
  );
  // Pads seen by the ports
  assign {i_port_b_pin, i_port_c_pin, i_port_d_pin} = lvl;

  // Free-running clock
  initial i_clk = 1'b0;
  always #4 i_clk = ~i_clk;

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask

  task give_verdict;
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task done(input string s);
    $display("test %s finished", s);
  endtask

  // One bus transfer; the note holds direction, error and read value
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic err);
    logic [31:0] r;
    r = $urandom();
    q.push_back({w, err, d});
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= {r[31:8], d};
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask

  task rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, e, 1'b0);
  endtask

  // Each answer is matched to the oldest note
  always @(posedge i_clk) begin
    if (o_pready === 1'b1) begin
      n = q.pop_front();
      if (!n[9]) chk("prdata", {24'h0, n[7:0]}, o_prdata);
      chk("pslverr", {31'h0, n[8]}, {31'h0, o_pslverr});
    end
  end

  // Hang guard, well above the expected run
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(32'h0202));
    {i_reset, i_ce, i_psel, i_penable, i_pwrite} = 5'h18;
    i_paddr = 12'h000;
    i_pwdata = 32'h0;
    i_pstrb = 4'hF;
    i_converter_channel_select = 5'h1F;
    ext = 20'h0;
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    rd(12'h014, 8'h00);
    rd(12'h018, 8'h00);
    rd(12'h01C, 8'h00);
    apb(1'b0, 12'h010, 8'h00, 1'b1);
    apb(1'b1, 12'h010, 8'h5A, 1'b1);
    // Write with byte lane 0 off is dropped
    i_pstrb <= 4'hE;
    wr(12'h014, 8'hFF);
    i_pstrb <= 4'hF;
    rd(12'h014, 8'h00);
    done("reset");
    // Latches loaded before the pins turn to outputs
    vb = 8'($urandom());
    vc = 8'($urandom());
    vd = 8'($urandom());
    wr(12'h004, vb);
    wr(12'h008, vc);
    wr(12'h00C, vd);
    wr(12'h014, 8'hFF);
    wr(12'h018, 8'h1F);
    wr(12'h01C, 8'hFF);
    rd(12'h01C, 8'h7F);
    rd(12'h004, vb);
    rd(12'h008, vc & 8'h1F);
    rd(12'h00C, vd & 8'h7F);
    // Pads driven from the latches
    chk("port_b_out", {24'h0, vb}, {24'h0, o_port_b_out});
    chk("port_b_oe", 32'h000000FF, {24'h0, o_port_b_oe});
    chk("port_c_out", {27'h0, vc[4:0]}, {27'h0, o_port_c_out});
    chk("port_c_oe", 32'h0000001F, {27'h0, o_port_c_oe});
    chk("port_d_out", {25'h0, vd[6:0]}, {25'h0, o_port_d_out});
    chk("port_d_oe", 32'h0000007F, {25'h0, o_port_d_oe});
    done("outputs");
    // Inputs show the outside level; a latch write stays hidden
    ext <= 20'($urandom());
    wr(12'h014, 8'h00);
    wr(12'h018, 8'h00);
    wr(12'h01C, 8'h00);
    vb = ~vb;
    wr(12'h004, vb);
    repeat (4) @(posedge i_clk);
    rd(12'h004, ext[19:12]);
    rd(12'h008, {3'h0, ext[11:7]});
    rd(12'h00C, {1'h0, ext[6:0]});
    done("inputs");
    // Channel selects 0 to 15, pins as inputs and as outputs
    for (int ch = 0; ch < 16; ch++) begin
      i_converter_channel_select <= 5'(ch);
      wr(12'h014, 8'h00);
      wr(12'h01C, 8'h00);
      repeat (4) @(posedge i_clk);
      rd(12'h004, ext[19:12] & ~(8'h01 << ch));
      rd(12'h00C, {1'h0, ext[6:0]} & ~(8'h01 << (ch - 8)));
      wr(12'h014, 8'hFF);
      wr(12'h01C, 8'h7F);
      rd(12'h004, vb);
      rd(12'h00C, vd & 8'h7F);
      chk("port_b_oe", {24'h0, ~(8'h01 << ch)}, {24'h0, o_port_b_oe});
      chk("port_d_oe", {25'h0, ~(7'h01 << (ch - 8))}, {25'h0, o_port_d_oe});
    end
    done("channels");
    wr(12'h018, 8'h80);
    rd(12'h018, 8'h80);
    repeat (8) @(posedge i_clk);
    chk("port_c_oe", 32'h00000004, {27'h0, o_port_c_oe});
    // Clock enable low freezes the toggling pad
    i_ce <= 1'b0;
    repeat (2) @(posedge i_clk);
    vd = {3'h0, o_port_c_out};
    repeat (3) @(posedge i_clk);
    chk("frozen port_c_out", {24'h0, vd}, {27'h0, o_port_c_out});
    i_ce <= 1'b1;
    done("clock out");
    // Second reset clears directions, keeps latches
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    rd(12'h014, 8'h00);
    rd(12'h018, 8'h00);
    wr(12'h014, 8'hFF);
    wr(12'h018, 8'h1F);
    rd(12'h004, vb);
    rd(12'h008, vc & 8'h1F);
    done("second reset");
    give_verdict();
  end
endmodule

bind sgp_gpio_top sgp_sva sgp_sva_inst (.*);
